// ---- src/sas_pkg.sv ----
// sas_pkg: constants and types for the setpoint action sequencer
// assumes a single 20 MHz clock domain, registers on a plain strobed port with a 4-bit address map
package sas_pkg;
  localparam int unsigned WEIGHT_W     = 24;
  localparam int unsigned COUNT_W      = 16;
  localparam int unsigned INDEX_W      = 5;
  localparam int unsigned PCT_W        = 16;
  localparam int unsigned PCT_FRAC     = 7;
  localparam logic [23:0] BAND_MAX     = 24'h98967F;
  localparam logic [23:0] BAND_RST     = 24'h000000;
  localparam logic [15:0] LIMIT_RST    = 16'h0001;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [4:0]  INDEX_RST    = 5'h00;
  localparam logic [31:0] PCT_SCALE    = 32'h00000064;
  localparam int unsigned NUM_SETPT    = 32;
  localparam int unsigned REG_ADDR_W   = 4;
  localparam logic [3:0]  REG_BAND     = 4'h0;
  localparam logic [3:0]  REG_LIMIT    = 4'h1;
  localparam logic [3:0]  REG_REL      = 4'h2;
  localparam logic [3:0]  REG_OWNVAL   = 4'h3;
  localparam logic [3:0]  REG_OPTS     = 4'h4;
  localparam logic [3:0]  REG_LINK     = 4'h5;
  localparam logic [3:0]  REG_TARGET   = 4'h6;
  localparam logic [3:0]  REG_STATUS   = 4'h7;
  localparam logic [3:0]  REG_COUNT    = 4'h8;
  localparam logic [3:0]  REG_TOTAL    = 4'h9;
  localparam logic [3:0]  REG_TARE     = 4'hA;

  typedef enum logic [2:0] {
    SAS_REL_NONE,
    SAS_REL_ADD,
    SAS_REL_SUB,
    SAS_REL_PCT,
    SAS_REL_RES
  } sas_rel_e;

  typedef enum logic [1:0] {
    SAS_ACC_OFF,
    SAS_ACC_ON,
    SAS_ACC_QUIET
  } sas_acc_e;

  typedef enum logic [1:0] {
    SAS_PRN_OFF,
    SAS_PRN_ON,
    SAS_PRN_WAIT
  } sas_prn_e;

  // option register bit positions
  localparam int unsigned OPT_BATCH    = 0;
  localparam int unsigned OPT_ZERO_TOT = 1;
  localparam int unsigned OPT_DROP_TAR = 2;
  localparam int unsigned OPT_ACC_LO   = 3;
  localparam int unsigned OPT_PRN_LO   = 5;
  localparam int unsigned OPT_CAP_TAR  = 7;
  localparam int unsigned OPT_ALARM    = 8;
  localparam int unsigned OPT_HILO     = 9;
  localparam int unsigned OPT_REL_LO   = 10;
endpackage

// ---- src/sas_top.sv ----
// sas_top: tolerance check, relative target, completion action sequencing
// assumes weight, standstill and operator inputs come from pins or another clock
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns

// How it works
// - check captured weight against tolerance band
// - skip preact learning when out of tolerance
// - count consecutive out-of-tolerance cycles against limit
// - pause and flag error until restart/reset
// - zero limit never pauses
// - reference index picks one of 32 setpoints
// - additive target is reference plus own
// - subtractive target is reference minus own
// - percent target uses reference target
// - result percent uses reference captured weight
// - batch bit selects batch or continuous
// - clear accumulator on satisfaction
// - clear tare on satisfaction
// - accumulate off, on with print, quiet
// - print off, immediate, after standstill
// - acquire tare ignoring regulatory mode
// - actions run in fixed order
// - alarm while active or untripped
// - start when starting setpoint begins
// - stop when ending setpoint begins
// - output active until met, continuous after met
module sas_top (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  clk_en_i,
  // register port
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  // scale side
  input  wire logic [23:0]           weight_i,
  input  wire logic                  standstill_i,
  input  wire logic                  regulatory_mode_i,
  // operator batch controls
  input  wire logic                  batch_restart_i,
  input  wire logic                  batch_reset_i,
  // sequence side
  input  wire logic                  satisfied_i,
  input  wire logic                  active_i,
  input  wire logic [31:0]           setpt_begin_i,
  input  wire logic [23:0]           ref_value_i,
  input  wire logic [23:0]           ref_target_i,
  input  wire logic [23:0]           ref_captured_i,
  output logic      [4:0]            ref_index_o,
  // results
  output logic      [23:0]           target_o,
  output logic                       batch_pause_o,
  output logic                       tol_error_o,
  output logic                       learn_enable_o,
  output logic                       alarm_o,
  output logic                       run_o,
  output logic                       dig_out_n_o,
  output logic                       zero_total_o,
  output logic                       drop_tare_o,
  output logic                       accumulate_o,
  output logic                       print_o,
  output logic                       capture_tare_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [23:0] wt_s1_ff, wt_ff;
  logic [5:0]  pin_s1_ff, pin_ff;
  logic [31:0] beg_s1_ff, beg_ff, beg_prev_ff;
  logic        stand_ff, regmode_ff, restart_ff, breset_ff, sat_ff, act_ff;
  assign {stand_ff, regmode_ff, restart_ff, breset_ff, sat_ff, act_ff} = pin_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wt_s1_ff    <= 24'h000000;
      wt_ff       <= 24'h000000;
      pin_s1_ff   <= 6'h00;
      pin_ff      <= 6'h00;
      beg_s1_ff   <= 32'h00000000;
      beg_ff      <= 32'h00000000;
      beg_prev_ff <= 32'h00000000;
    end else if (clk_en_i) begin
      wt_s1_ff    <= weight_i;
      wt_ff       <= wt_s1_ff;
      pin_s1_ff   <= {standstill_i, regulatory_mode_i, batch_restart_i,
                      batch_reset_i, satisfied_i, active_i};
      pin_ff      <= pin_s1_ff;
      beg_s1_ff   <= setpt_begin_i;
      beg_ff      <= beg_s1_ff;
      beg_prev_ff <= beg_ff;
    end
  end

  logic sat_prev_ff;
  logic sat_rise;
  logic [31:0] beg_rise;
  assign sat_rise = sat_ff & ~sat_prev_ff;
  assign beg_rise = beg_ff & ~beg_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [23:0] band_ff;
  logic [15:0] limit_ff;
  logic [4:0]  rel_idx_ff;
  logic [23:0] own_val_ff;
  logic [12:0] opts_ff;
  logic [4:0]  start_idx_ff, end_idx_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      band_ff      <= sas_pkg::BAND_RST;
      limit_ff     <= sas_pkg::LIMIT_RST;
      rel_idx_ff   <= sas_pkg::INDEX_RST;
      own_val_ff   <= 24'h000000;
      opts_ff      <= 13'h0000;
      start_idx_ff <= sas_pkg::INDEX_RST;
      end_idx_ff   <= sas_pkg::INDEX_RST;
    end else if (clk_en_i && reg_wr_i) begin
      case (reg_addr_i)
        sas_pkg::REG_BAND: begin
          // band saturates at its documented ceiling
          band_ff <= (reg_wdata_i[23:0] > sas_pkg::BAND_MAX) ? sas_pkg::BAND_MAX
                                                              : reg_wdata_i[23:0];
        end
        sas_pkg::REG_LIMIT:  limit_ff   <= reg_wdata_i[15:0];
        sas_pkg::REG_REL:    rel_idx_ff <= reg_wdata_i[4:0];
        sas_pkg::REG_OWNVAL: own_val_ff <= reg_wdata_i[23:0];
        sas_pkg::REG_OPTS:   opts_ff    <= reg_wdata_i[12:0];
        sas_pkg::REG_LINK: begin
          start_idx_ff <= reg_wdata_i[4:0];
          end_idx_ff   <= reg_wdata_i[12:8];
        end
        default: ;
      endcase
    end
  end

  logic             is_batch, is_hilo;
  sas_pkg::sas_acc_e acc_mode;
  sas_pkg::sas_prn_e prn_mode;
  sas_pkg::sas_rel_e rel_mode;
  assign is_batch = opts_ff[sas_pkg::OPT_BATCH];
  assign is_hilo  = opts_ff[sas_pkg::OPT_HILO];
  assign acc_mode = sas_pkg::sas_acc_e'(opts_ff[sas_pkg::OPT_ACC_LO +: 2]);
  assign prn_mode = sas_pkg::sas_prn_e'(opts_ff[sas_pkg::OPT_PRN_LO +: 2]);
  assign rel_mode = sas_pkg::sas_rel_e'(opts_ff[sas_pkg::OPT_REL_LO +: 3]);

  ////////////////////////////////////////////////////////////////////////////
  // relative target
  logic [23:0] nxt_target;
  logic [47:0] pct_prod;
  logic [23:0] pct_base;
  always_comb begin
    pct_base = (rel_mode == sas_pkg::SAS_REL_RES) ? ref_captured_i
                                                  : ref_target_i;
    pct_prod = 48'(pct_base) * 48'(own_val_ff) / 48'(sas_pkg::PCT_SCALE);
    case (rel_mode)
      sas_pkg::SAS_REL_ADD: nxt_target = ref_value_i + own_val_ff;
      sas_pkg::SAS_REL_SUB: nxt_target = ref_value_i - own_val_ff;
      sas_pkg::SAS_REL_PCT,
      sas_pkg::SAS_REL_RES: nxt_target = pct_prod[23:0];
      default:              nxt_target = own_val_ff;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_o    <= 24'h000000;
      ref_index_o <= sas_pkg::INDEX_RST;
    end else if (clk_en_i) begin
      target_o    <= nxt_target;
      ref_index_o <= rel_idx_ff - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tolerance check and fail counter
  logic [24:0] lo_lim, hi_lim;
  logic        out_tol;
  logic [15:0] fail_cnt_ff;
  assign lo_lim  = {1'b0, target_o} - {1'b0, band_ff};
  assign hi_lim  = {1'b0, target_o} + {1'b0, band_ff};
  assign out_tol = lo_lim[24] ? ({1'b0, wt_ff} > hi_lim)
                              : (({1'b0, wt_ff} < lo_lim) || ({1'b0, wt_ff} > hi_lim));

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sat_prev_ff    <= 1'b0;
      fail_cnt_ff    <= sas_pkg::COUNT_ZERO;
      tol_error_o    <= 1'b0;
      batch_pause_o  <= 1'b0;
      learn_enable_o <= 1'b0;
    end else if (clk_en_i) begin
      sat_prev_ff <= sat_ff;
      if (breset_ff) begin
        fail_cnt_ff <= sas_pkg::COUNT_ZERO;
      end else if (sat_rise && is_batch && is_hilo) begin
        if (out_tol) begin
          fail_cnt_ff <= fail_cnt_ff + 16'h0001;
        end else begin
          fail_cnt_ff <= sas_pkg::COUNT_ZERO;
        end
      end
      if (sat_rise && is_batch && is_hilo) begin
        learn_enable_o <= !out_tol;
      end
      if (sat_rise && is_batch && is_hilo && out_tol && limit_ff != sas_pkg::COUNT_ZERO
          && (fail_cnt_ff + 16'h0001) >= limit_ff) begin
        tol_error_o   <= 1'b1;
        batch_pause_o <= 1'b1;
      end else if (restart_ff || breset_ff) begin
        tol_error_o   <= 1'b0;
        batch_pause_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion action sequence
  typedef enum logic [2:0] {
    SAS_IDLE, SAS_ZTOT, SAS_DTAR, SAS_ACC, SAS_PRN, SAS_PRINT_AFTER_STANDSTILL, SAS_CTAR
  } sas_step_e;
  sas_step_e step_ff;
  logic      acc_print_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_ff        <= SAS_IDLE;
      acc_print_ff   <= 1'b0;
      zero_total_o   <= 1'b0;
      drop_tare_o    <= 1'b0;
      accumulate_o   <= 1'b0;
      print_o        <= 1'b0;
      capture_tare_o <= 1'b0;
    end else if (clk_en_i) begin
      zero_total_o   <= 1'b0;
      drop_tare_o    <= 1'b0;
      accumulate_o   <= 1'b0;
      print_o        <= 1'b0;
      capture_tare_o <= 1'b0;
      case (step_ff)
        SAS_IDLE: if (sat_rise) step_ff <= SAS_ZTOT;
        SAS_ZTOT: begin
          zero_total_o <= opts_ff[sas_pkg::OPT_ZERO_TOT];
          step_ff      <= SAS_DTAR;
        end
        SAS_DTAR: begin
          drop_tare_o <= opts_ff[sas_pkg::OPT_DROP_TAR];
          step_ff     <= SAS_ACC;
        end
        SAS_ACC: begin
          accumulate_o <= (acc_mode == sas_pkg::SAS_ACC_ON)
                          || (acc_mode == sas_pkg::SAS_ACC_QUIET);
          acc_print_ff <= (acc_mode == sas_pkg::SAS_ACC_ON);
          step_ff      <= SAS_PRN;
        end
        SAS_PRN: begin
          if (prn_mode == sas_pkg::SAS_PRN_WAIT && !stand_ff) begin
            step_ff <= SAS_PRINT_AFTER_STANDSTILL;
          end else begin
            print_o <= acc_print_ff || (prn_mode != sas_pkg::SAS_PRN_OFF);
            step_ff <= SAS_CTAR;
          end
        end
        SAS_PRINT_AFTER_STANDSTILL: begin
          if (stand_ff) begin
            print_o <= 1'b1;
            step_ff <= SAS_CTAR;
          end
        end
        SAS_CTAR: begin
          // regulatory mode deliberately not consulted
          capture_tare_o <= opts_ff[sas_pkg::OPT_CAP_TAR];
          step_ff        <= SAS_IDLE;
        end
        default: step_ff <= SAS_IDLE;
      endcase
      if (breset_ff) step_ff <= SAS_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm, output, start/stop linkage
  logic start_hit, end_hit;
  assign start_hit = (start_idx_ff != sas_pkg::INDEX_RST) && beg_rise[start_idx_ff - 5'h01];
  assign end_hit   = (end_idx_ff   != sas_pkg::INDEX_RST) && beg_rise[end_idx_ff - 5'h01];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_o     <= 1'b0;
      run_o       <= 1'b0;
      dig_out_n_o <= 1'b1;
    end else if (clk_en_i) begin
      alarm_o <= opts_ff[sas_pkg::OPT_ALARM]
                 && (is_batch ? act_ff : !sat_ff);
      if (breset_ff || end_hit) begin
        run_o <= 1'b0;
      end else if (start_hit) begin
        run_o <= 1'b1;
      end
      dig_out_n_o <= is_batch ? !(act_ff && !sat_ff) : !sat_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (clk_en_i) begin
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          sas_pkg::REG_BAND:   reg_rdata_o <= {8'h00, band_ff};
          sas_pkg::REG_LIMIT:  reg_rdata_o <= {16'h0000, limit_ff};
          sas_pkg::REG_REL:    reg_rdata_o <= {27'h0000000, rel_idx_ff};
          sas_pkg::REG_OWNVAL: reg_rdata_o <= {8'h00, own_val_ff};
          sas_pkg::REG_OPTS:   reg_rdata_o <= {19'h00000, opts_ff};
          sas_pkg::REG_LINK:   reg_rdata_o <= {19'h00000, end_idx_ff, 3'h0, start_idx_ff};
          sas_pkg::REG_TARGET: reg_rdata_o <= {8'h00, target_o};
          sas_pkg::REG_STATUS: reg_rdata_o <= {27'h0000000, run_o, alarm_o,
                                               learn_enable_o, batch_pause_o, tol_error_o};
          sas_pkg::REG_COUNT:  reg_rdata_o <= {16'h0000, fail_cnt_ff};
          default:             reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_zero_limit_safe: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (limit_ff == sas_pkg::COUNT_ZERO && !tol_error_o) |=> !tol_error_o || $changed(limit_ff))
    else $error("pause with zero limit");
  a_action_order: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && step_ff == SAS_ZTOT) |=> step_ff == SAS_DTAR)
    else $error("action order broken");
  a_reset_clears_cnt: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && breset_ff) |=> fail_cnt_ff == sas_pkg::COUNT_ZERO)
    else $error("counter not cleared");
  a_band_ceiling: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    band_ff <= sas_pkg::BAND_MAX)
    else $error("band above ceiling");
  a_error_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && tol_error_o && (restart_ff || breset_ff) && !sat_rise) |=> !tol_error_o)
    else $error("error not cleared");
  a_quiet_no_print: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (clk_en_i && step_ff == SAS_ACC && acc_mode == sas_pkg::SAS_ACC_QUIET
     && prn_mode == sas_pkg::SAS_PRN_OFF) |=> ##1 !print_o)
    else $error("quiet mode printed");
  a_pause_tracks_err: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    batch_pause_o == tol_error_o)
    else $error("pause and error differ");
  a_tare_after_prn: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    capture_tare_o |-> $past(step_ff) == SAS_CTAR)
    else $error("tare out of order");
  c_pause: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(batch_pause_o));
  c_print: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(print_o));
  c_run:   cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(run_o));

endmodule // sas_top

// ---- verification/sas_scale_model.sv ----
// sas_scale_model: scale weight, standstill and operator batch controls
// assumes one shared clock with the block; the bench calls its tasks
`timescale 1ns/1ns
module sas_scale_model (
  // clock
  input  wire logic        ref_clk_i,
  // scale side
  output logic      [23:0] weight_o,
  output logic             standstill_o,
  output logic             regulatory_mode_o,
  // operator and sequence controls
  output logic             batch_restart_o,
  output logic             batch_reset_o,
  output logic             satisfied_o
);
  initial begin
    weight_o          = 24'h000000;
    standstill_o      = 1'b0;
    regulatory_mode_o = 1'b0;
    batch_restart_o   = 1'b0;
    batch_reset_o     = 1'b0;
    satisfied_o       = 1'b0;
  end
  task automatic settle(input logic [23:0] w, input logic ss, input logic reg_m);
    @(posedge ref_clk_i);
    weight_o          <= w;
    standstill_o      <= ss;
    regulatory_mode_o <= reg_m;
  endtask
  // weight settles first, then the setpoint is satisfied, then drops long enough to rearm
  task automatic batch_cycle(input logic [23:0] w);
    settle(w, standstill_o, regulatory_mode_o);
    repeat (4) @(posedge ref_clk_i);
    satisfied_o <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    satisfied_o <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
  endtask
  // operator key held several cycles so the input synchroniser sees it
  task automatic press(input logic restart);
    @(posedge ref_clk_i);
    batch_restart_o <= restart;
    batch_reset_o   <= !restart;
    repeat (3) @(posedge ref_clk_i);
    batch_restart_o <= 1'b0;
    batch_reset_o   <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask
endmodule // sas_scale_model

// ---- verification/testbench.sv ----
// testbench: directed scenarios for the setpoint action sequencer
// assumes sas_pkg and sas_top compiled first, scale model from sas_scale_model
`timescale 1ns/1ns
module testbench;
  logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, active_i;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, setpt_begin_i;
  logic [23:0] weight_i, ref_value_i, ref_target_i, ref_captured_i, target_o;
  logic standstill_i, regulatory_mode_i, batch_restart_i, batch_reset_i, satisfied_i;
  logic [4:0] ref_index_o;
  logic batch_pause_o, tol_error_o, learn_enable_o, alarm_o, run_o, dig_out_n_o;
  logic zero_total_o, drop_tare_o, accumulate_o, print_o, capture_tare_o;
  logic [4:0] act;
  logic clk_en;
  int bad_count, samples_checked, cyc;
  int hits[5];
  int first_at[5];
  logic [31:0] rv;
  assign act = {capture_tare_o, print_o, accumulate_o, drop_tare_o, zero_total_o};
  sas_top dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .weight_i(weight_i),
    .standstill_i(standstill_i), .regulatory_mode_i(regulatory_mode_i),
    .batch_restart_i(batch_restart_i), .batch_reset_i(batch_reset_i),
    .satisfied_i(satisfied_i), .active_i(active_i), .setpt_begin_i(setpt_begin_i),
    .ref_value_i(ref_value_i), .ref_target_i(ref_target_i),
    .ref_captured_i(ref_captured_i), .ref_index_o(ref_index_o), .target_o(target_o),
    .batch_pause_o(batch_pause_o), .tol_error_o(tol_error_o),
    .learn_enable_o(learn_enable_o), .alarm_o(alarm_o), .run_o(run_o),
    .dig_out_n_o(dig_out_n_o), .zero_total_o(zero_total_o), .drop_tare_o(drop_tare_o),
    .accumulate_o(accumulate_o), .print_o(print_o), .capture_tare_o(capture_tare_o));
  sas_scale_model scale_u (.ref_clk_i(ref_clk_i), .weight_o(weight_i),
    .standstill_o(standstill_i), .regulatory_mode_o(regulatory_mode_i),
    .batch_restart_o(batch_restart_i), .batch_reset_o(batch_reset_i),
    .satisfied_o(satisfied_i));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = !ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 5; i++) begin
      if (act[i] === 1'b1) begin
        hits[i]++;
        first_at[i] = cyc;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic settle_wait();
    repeat (6) @(posedge ref_clk_i);
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rd(sas_pkg::REG_BAND, rv);
    chk("band reset", 32'h00000000, rv);
    rd(sas_pkg::REG_LIMIT, rv);
    chk("limit reset", 32'h00000001, rv);
    wr(sas_pkg::REG_BAND, 32'h0098967F);
    rd(sas_pkg::REG_BAND, rv);
    chk("band max", 32'h0098967F, rv);
    wr(sas_pkg::REG_BAND, 32'h00FFFFFF);
    rd(sas_pkg::REG_BAND, rv);
    chk("band ceiling", 32'h0098967F, rv);
    rd(4'hF, rv);
    chk("unmapped read", 32'h00000000, rv);
  endtask
  task automatic t_relative();
    logic [31:0] ex[4];
    ex = '{32'h000004B0, 32'h00000320, 32'h000001F4, 32'h000002EE};
    wr(sas_pkg::REG_REL, 32'h00000020);
    settle_wait();
    chk("ref index", 32'h0000001F, {27'h0, ref_index_o});
    wr(sas_pkg::REG_OWNVAL, 32'h000000C8);
    for (int m = 1; m <= 4; m++) begin
      wr(sas_pkg::REG_OPTS, 32'(m) << sas_pkg::OPT_REL_LO);
      if (m == 4) wr(sas_pkg::REG_OWNVAL, 32'h00000019);
      if (m == 3) wr(sas_pkg::REG_OWNVAL, 32'h00000032);
      settle_wait();
      chk("target", ex[m-1], {8'h0, target_o});
    end
    ref_captured_i <= 24'h0007D0;
    ref_target_i   <= 24'h0000C8;
    settle_wait();
    chk("result base", 32'h000001F4, {8'h0, target_o});
    ref_value_i <= 24'h0007D0;
    wr(sas_pkg::REG_OPTS, 32'h00000400);
    settle_wait();
    chk("add base", 32'h000007E9, {8'h0, target_o});
    rd(sas_pkg::REG_TARGET, rv);
    chk("target read", 32'h000007E9, rv);
    ref_value_i <= 24'h0003E8;
  endtask
  task automatic t_freeze();
    clk_en <= 1'b0;
    wr(sas_pkg::REG_LIMIT, 32'h00000005);
    clk_en <= 1'b1;
    rd(sas_pkg::REG_LIMIT, rv);
    chk("frozen write", 32'h00000000, rv);
  endtask
  task automatic t_tolerance();
    wr(sas_pkg::REG_OWNVAL, 32'h00000000);
    wr(sas_pkg::REG_BAND, 32'h0000000A);
    wr(sas_pkg::REG_LIMIT, 32'h00000002);
    wr(sas_pkg::REG_OPTS, 32'h00000601);
    scale_u.batch_cycle(24'h00044C);
    chk("learn out", 32'h0, {31'h0, learn_enable_o});
    rd(sas_pkg::REG_COUNT, rv);
    chk("count one", 32'h1, rv);
    chk("no pause yet", 32'h0, {31'h0, batch_pause_o});
    scale_u.batch_cycle(24'h0003F1);
    chk("learn in", 32'h1, {31'h0, learn_enable_o});
    rd(sas_pkg::REG_COUNT, rv);
    chk("count cleared", 32'h0, rv);
    scale_u.batch_cycle(24'h0003D3);
    chk("learn low", 32'h0, {31'h0, learn_enable_o});
    scale_u.batch_cycle(24'h00044C);
    chk("pause", 32'h1, {31'h0, batch_pause_o});
    chk("error", 32'h1, {31'h0, tol_error_o});
    rd(sas_pkg::REG_STATUS, rv);
    chk("status paused", 32'h00000003, rv);
    scale_u.press(1'b1);
    chk("pause restart", 32'h0, {31'h0, batch_pause_o});
    chk("error restart", 32'h0, {31'h0, tol_error_o});
    wr(sas_pkg::REG_LIMIT, 32'h00000000);
    repeat (3) scale_u.batch_cycle(24'h00044C);
    chk("zero limit", 32'h0, {31'h0, batch_pause_o});
    scale_u.press(1'b0);
    rd(sas_pkg::REG_COUNT, rv);
    chk("count reset", 32'h0, rv);
  endtask
  task automatic run_actions(input logic [31:0] opts);
    wr(sas_pkg::REG_OPTS, opts);
    foreach (hits[i]) hits[i] = 0;
    scale_u.batch_cycle(24'h000100);
  endtask
  task automatic t_actions();
    scale_u.settle(24'h000100, 1'b1, 1'b1);
    run_actions(32'h000000AF);
    for (int i = 0; i < 5; i++) chk("action once", 32'h1, 32'(hits[i]));
    for (int i = 0; i < 4; i++) chk("action step", 32'h1, 32'(first_at[i+1] - first_at[i]));
    run_actions(32'h00000011);
    chk("quiet acc", 32'h1, 32'(hits[2]));
    chk("quiet print", 32'h0, 32'(hits[3]));
    run_actions(32'h00000009);
    chk("acc print", 32'h1, 32'(hits[3]));
    run_actions(32'h00000021);
    chk("print now", 32'h1, 32'(hits[3]));
    scale_u.settle(24'h000100, 1'b0, 1'b0);
    run_actions(32'h00000041);
    chk("print held", 32'h0, 32'(hits[3]));
    scale_u.settle(24'h000100, 1'b1, 1'b0);
    settle_wait();
    chk("print standstill", 32'h1, 32'(hits[3]));
  endtask
  task automatic t_alarm();
    wr(sas_pkg::REG_OPTS, 32'h00000101);
    active_i <= 1'b1;
    settle_wait();
    chk("alarm batch", 32'h1, {31'h0, alarm_o});
    chk("out batch", 32'h0, {31'h0, dig_out_n_o});
    active_i <= 1'b0;
    settle_wait();
    chk("alarm idle", 32'h0, {31'h0, alarm_o});
    wr(sas_pkg::REG_OPTS, 32'h00000100);
    settle_wait();
    chk("alarm cont", 32'h1, {31'h0, alarm_o});
    chk("out cont", 32'h1, {31'h0, dig_out_n_o});
    wr(sas_pkg::REG_LINK, 32'h00000703);
    setpt_begin_i <= 32'h00000004;
    settle_wait();
    chk("run start", 32'h1, {31'h0, run_o});
    setpt_begin_i <= 32'h00000040;
    settle_wait();
    chk("run stop", 32'h0, {31'h0, run_o});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, active_i} = 4'h0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h00000000;
    setpt_begin_i = 32'h00000000;
    ref_value_i = 24'h0003E8;
    ref_target_i = 24'h0003E8;
    ref_captured_i = 24'h000BB8;
    bad_count = 0;
    samples_checked = 0;
    cyc = 0;
    clk_en = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_defaults();
    t_relative();
    t_tolerance();
    t_actions();
    t_alarm();
    t_freeze();
    close_out();
  end
  initial begin
    #1000000;
    bad_count++;
    close_out();
  end
endmodule // testbench
